// *** oalu_core.sv ***
// Logical instruction datapath with operand addressing and mapped pointer registers
`timescale 1ns/10ps
module oalu_core
	import oalu_pkg::*;
(
	input  wire logic                       CORE_CLK,
	input  wire logic                       NRST,
	input  wire logic                       CLK_EN,
	input  wire logic                       INSTR_VALID,
	input  wire oalu_pkg::oalu_instr_t      INSTR,
	input  wire logic [7:0]                 MEM_RDATA,
	input  wire logic                       LOW_SUPPLY_EVT,
	input  wire logic                       TIMEOUT_EVT,
	input  wire logic [7:0]                 PC_LOW_IN,
	output oalu_pkg::oalu_mem_t             MEM,
	output logic [7:0]                      ACC,
	output logic [7:0]                      FLAGS,
	output logic                            PC_LOW_WE,
	output logic [7:0]                      PC_LOW_OUT,
	output logic [oalu_pkg::TARGET_W-1:0]   TARGET_OUT,
	output logic                            ADDR_FAULT
);
	import oalu_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	logic [7:0]  acc_q, acc_d;
	logic [7:0]  flags_q, flags_d;
	logic [7:0]  ind_hi_q, ind_lo_q, stk_hi_q, stk_lo_q, dat_hi_q, dat_lo_q;
	oalu_mem_t   mem_q, mem_d;
	logic        pcwe_q;
	logic [7:0]  pcout_q;
	logic [TARGET_W-1:0] target_q;
	logic        fault_q;

	// ==========================================================
	// Operand addressing
	// ==========================================================
	wire [15:0] ip_ptr = {ind_hi_q, ind_lo_q};
	wire [15:0] dp_ptr = {dat_hi_q, dat_lo_q};
	wire [15:0] sp_ptr = {stk_hi_q, stk_lo_q};
	logic [15:0] op_addr;
	logic        op_direct;
	logic        op_legal;

	oalu_addr_gen u_addr_gen (
		.mode      (INSTR.mode),
		.field     (INSTR.field),
		.ip_ptr    (ip_ptr),
		.dp_ptr    (dp_ptr),
		.sp_ptr    (sp_ptr),
		.addr      (op_addr),
		.is_direct (op_direct),
		.legal     (op_legal)
	);

	function automatic logic [7:0] map_read(input logic [7:0] a, input logic [7:0] mem);
		case (a)
			ADR_IND_HI: map_read = ind_hi_q;
			ADR_IND_LO: map_read = ind_lo_q;
			ADR_STK_HI: map_read = stk_hi_q;
			ADR_STK_LO: map_read = stk_lo_q;
			ADR_PC_LOW: map_read = PC_LOW_IN;
			ADR_FLAGS:  map_read = flags_q;
			ADR_DAT_HI: map_read = dat_hi_q;
			ADR_DAT_LO: map_read = dat_lo_q;
			default:   map_read = mem;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADR_IND_HI) || (a == ADR_IND_LO) || (a == ADR_STK_HI)
			|| (a == ADR_STK_LO) || (a == ADR_PC_LOW) || (a == ADR_FLAGS)
			|| (a == ADR_DAT_HI) || (a == ADR_DAT_LO);
	endfunction

	// The indirect form also reaches the mapped bytes when its address lands there; offset forms below 0x20 are refused
	wire        low_page   = (op_addr[15:8] == 8'h00);
	wire [7:0]  low_byte   = op_addr[7:0];
	wire        hits_map   = low_page && is_mapped(low_byte);
	wire        exec       = CLK_EN && INSTR_VALID && (INSTR.op != OP_NONE);
	wire        is_imm     = (INSTR.mode == AM_IMMEDIATE);
	// File data is taken combinationally in the same cycle as the instruction
	wire [7:0]  file_val   = low_page ? map_read(low_byte, MEM_RDATA) : MEM_RDATA;
	wire [7:0]  operand    = is_imm ? INSTR.field : file_val;
	wire        file_dest  = INSTR.to_file && !is_imm && (INSTR.op != OP_NONE);
	wire        do_file_wr = exec && file_dest && op_legal;

	// ==========================================================
	// Logic unit
	// ==========================================================
	logic [7:0] result;
	always_comb
	begin
		case (INSTR.op)
			OP_AND:  result = acc_q & operand;
			OP_OR:   result = acc_q | operand;
			OP_XOR:  result = acc_q ^ operand;
			OP_NOT:  result = ~file_val;
			default: result = acc_q;
		endcase
	end

	wire result_zero = (result == RST_BYTE);
	// Complement has no literal form, so an immediate NOT is discarded
	wire op_ok = op_legal && !(INSTR.op == OP_NOT && is_imm) && !(is_imm && INSTR.to_file);

	always_comb
	begin
		acc_d = acc_q;
		flags_d = flags_q;
		if (exec && op_ok)
		begin
			if (!file_dest)
			begin
				acc_d = result;
			end
			flags_d[FLG_ZERO] = result_zero;
		end
		// A direct write of the flag byte lands first, zero update still wins
		if (do_file_wr && op_ok && hits_map && low_byte == ADR_FLAGS)
		begin
			flags_d = result;
			flags_d[FLG_ZERO] = result_zero;
		end
		if (LOW_SUPPLY_EVT && CLK_EN)
		begin
			flags_d[FLG_LOWSUP] = 1'b1;
		end
		if (TIMEOUT_EVT && CLK_EN)
		begin
			flags_d[FLG_TIMEOUT] = 1'b1;
		end
	end

	// ==========================================================
	// Memory side
	// ==========================================================
	always_comb
	begin
		mem_d = '0;
		if (exec && op_ok && !is_imm && !hits_map)
		begin
			mem_d.req = 1'b1;
			mem_d.we = file_dest;
			mem_d.addr = op_addr;
			mem_d.wdata = result;
		end
	end

	wire map_wr = exec && op_ok && do_file_wr && hits_map;

	// ==========================================================
	// Registers
	// ==========================================================
	// One strobe per mapped byte; the flag byte is loaded through flags_d
	wire wr_ind_hi = map_wr && (low_byte == ADR_IND_HI);
	wire wr_ind_lo = map_wr && (low_byte == ADR_IND_LO);
	wire wr_stk_hi = map_wr && (low_byte == ADR_STK_HI);
	wire wr_stk_lo = map_wr && (low_byte == ADR_STK_LO);
	wire wr_dat_hi = map_wr && (low_byte == ADR_DAT_HI);
	wire wr_dat_lo = map_wr && (low_byte == ADR_DAT_LO);
	wire wr_pc     = map_wr && (low_byte == ADR_PC_LOW);

	// Accumulator and flag byte
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			acc_q <= RST_BYTE;
			flags_q <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			acc_q <= acc_d;
			flags_q <= flags_d;
		end
	end

	// Memory request stands for one enabled cycle
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			mem_q <= '0;
		end
		else if (CLK_EN)
		begin
			mem_q <= mem_d;
		end
	end

	// Program counter low port
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			pcwe_q <= 1'b0;
			pcout_q <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			pcwe_q <= wr_pc;
			pcout_q <= result;
		end
	end

	// Address fault pulse
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			fault_q <= 1'b0;
		end
		else if (CLK_EN)
		begin
			fault_q <= exec && !op_legal;
		end
	end

	// Program target of the last instruction
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			target_q <= '0;
		end
		else if (CLK_EN && INSTR_VALID)
		begin
			target_q <= INSTR.target;
		end
	end

	// Indirect pointer pair
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			ind_hi_q <= RST_BYTE;
			ind_lo_q <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			if (wr_ind_hi)
			begin
				ind_hi_q <= result;
			end
			if (wr_ind_lo)
			begin
				ind_lo_q <= result;
			end
		end
	end

	// Data pointer pair
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			dat_hi_q <= RST_BYTE;
			dat_lo_q <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			if (wr_dat_hi)
			begin
				dat_hi_q <= result;
			end
			if (wr_dat_lo)
			begin
				dat_lo_q <= result;
			end
		end
	end

	// Stack pointer pair
	always_ff @(posedge CORE_CLK)
	begin
		if (!NRST)
		begin
			stk_hi_q <= RST_BYTE;
			stk_lo_q <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			if (wr_stk_hi)
			begin
				stk_hi_q <= result;
			end
			if (wr_stk_lo)
			begin
				stk_lo_q <= result;
			end
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign MEM = mem_q;
	assign ACC = acc_q;
	assign FLAGS = flags_q;
	assign PC_LOW_WE = pcwe_q;
	assign PC_LOW_OUT = pcout_q;
	assign TARGET_OUT = target_q;
	assign ADDR_FAULT = fault_q;
endmodule

// *** oalu_pkg.sv ***
// Package: constants and types for the operand addressing logic unit
package oalu_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int TARGET_W = 13;
	localparam logic [7:0] ADR_IND_HI = 8'h04;
	localparam logic [7:0] ADR_IND_LO = 8'h05;
	localparam logic [7:0] ADR_STK_HI = 8'h06;
	localparam logic [7:0] ADR_STK_LO = 8'h07;
	localparam logic [7:0] ADR_PC_LOW = 8'h09;
	localparam logic [7:0] ADR_FLAGS = 8'h0b;
	localparam logic [7:0] ADR_DAT_HI = 8'h0c;
	localparam logic [7:0] ADR_DAT_LO = 8'h0d;
	localparam logic [7:0] ADR_DIRECT_MIN = 8'h01;
	localparam logic [15:0] ADR_OFFSET_MIN = 16'h0020;
	localparam int FLG_CARRY = 0;
	localparam int FLG_NIBBLE = 1;
	localparam int FLG_ZERO = 2;
	localparam int FLG_LOWSUP = 3;
	localparam int FLG_TIMEOUT = 4;
	localparam int FLG_PAGE_LSB = 5;
	localparam int FLG_PAGE_MSB = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ADDR = 16'h0000;

	typedef enum logic [2:0] {
		AM_IMMEDIATE,
		AM_DIRECT,
		AM_INDIRECT,
		AM_DP_OFFSET,
		AM_SP_OFFSET
	} oalu_mode_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_NOT
	} oalu_op_t;

	typedef struct packed {
		oalu_op_t          op;
		oalu_mode_t        mode;
		logic              to_file;
		logic [7:0]        field;
		logic [TARGET_W-1:0] target;
	} oalu_instr_t;

	typedef struct packed {
		logic              req;
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} oalu_mem_t;
endpackage

// *** oalu_addr_gen.sv ***
// Operand address generator for the file operand path
`timescale 1ns/10ps
module oalu_addr_gen
	import oalu_pkg::*;
(
	input  wire oalu_pkg::oalu_mode_t mode,
	input  wire logic [7:0]           field,
	input  wire logic [15:0]          ip_ptr,
	input  wire logic [15:0]          dp_ptr,
	input  wire logic [15:0]          sp_ptr,
	output logic [15:0]               addr,
	output logic                      is_direct,
	output logic                      legal
);
	wire [15:0] dp_sum;
	wire [15:0] sp_sum;
	wire        offset_mode;

	// Offset is unsigned and zero-extended; the sum wraps at 16 bits
	assign dp_sum = dp_ptr + {8'h00, field};
	assign sp_sum = sp_ptr + {8'h00, field};
	assign offset_mode = (mode == AM_DP_OFFSET) || (mode == AM_SP_OFFSET);

	always_comb
	begin
		addr = RST_ADDR;
		case (mode)
			AM_DIRECT:    addr = {8'h00, field};
			AM_INDIRECT:  addr = ip_ptr;
			AM_DP_OFFSET: addr = dp_sum;
			AM_SP_OFFSET: addr = sp_sum;
			default:      addr = RST_ADDR;
		endcase
	end

	assign is_direct = (mode == AM_DIRECT);
	// Address 0x00 has no direct form; low offset results are flagged and blocked
	// A literal operand has no address, so it is never a fault
	assign legal = (is_direct && field >= ADR_DIRECT_MIN)
		|| (mode == AM_IMMEDIATE)
		|| (mode == AM_INDIRECT)
		|| (offset_mode && addr >= ADR_OFFSET_MIN);
endmodule

// *** oalu_asserts.sv ***
// Concurrent checks on the ports of the logical datapath core
`timescale 1ns/10ps
module oalu_asserts
	import oalu_pkg::*;
(
	input wire logic                    CORE_CLK,
	input wire logic                    NRST,
	input wire logic                    CLK_EN,
	input wire logic                    INSTR_VALID,
	input wire oalu_pkg::oalu_instr_t   INSTR,
	input wire logic [7:0]              MEM_RDATA,
	input wire oalu_pkg::oalu_mem_t     MEM,
	input wire logic [7:0]              ACC,
	input wire logic [7:0]              FLAGS,
	input wire logic                    PC_LOW_WE,
	input wire logic [TARGET_W-1:0]     TARGET_OUT,
	input wire logic                    ADDR_FAULT
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// Result checks use immediate and direct forms only: other file forms depend on pointers the checker cannot see
	wire logic tk = CLK_EN && INSTR_VALID && INSTR.op != OP_NONE;
	wire logic im = tk && INSTR.mode == AM_IMMEDIATE && !INSTR.to_file;
	wire logic dr = tk && INSTR.mode == AM_DIRECT;
	// ====================
	// Checks
	AST_IMM_AND: assert property (im && INSTR.op == OP_AND |=> ACC == ($past(ACC) & $past(INSTR.field)))
		else $error("and literal result wrong");
	AST_IMM_OR: assert property (im && INSTR.op == OP_OR |=> ACC == ($past(ACC) | $past(INSTR.field)))
		else $error("or literal result wrong");
	AST_ZERO: assert property (im && INSTR.op != OP_NOT |=> FLAGS[FLG_ZERO] == (ACC == 8'h00))
		else $error("zero flag wrong");
	AST_NOT_MEM: assert property (dr && INSTR.op == OP_NOT && !INSTR.to_file && INSTR.field > 8'h0d |=> ACC == ~$past(MEM_RDATA))
		else $error("complement result wrong");
	AST_DIRECT_FAULT: assert property (dr && INSTR.field == 8'h00 |=> ADDR_FAULT && !MEM.we)
		else $error("direct zero not refused");
	AST_PC_WRITE: assert property (dr && INSTR.field == ADR_PC_LOW && INSTR.to_file |=> PC_LOW_WE)
		else $error("program counter write missing");
	AST_CARRY_KEEP: assert property (tk && !INSTR.to_file |=> FLAGS[1:0] == $past(FLAGS[1:0]))
		else $error("carry flags changed");
	AST_TARGET: assert property (tk |=> TARGET_OUT == $past(INSTR.target))
		else $error("target not held");
	COV_IND: cover property (tk && INSTR.mode == AM_INDIRECT);
	COV_FAULT: cover property (ADDR_FAULT);
	COV_PC: cover property (PC_LOW_WE);
endmodule
bind oalu_core oalu_asserts oalu_asserts_i (.CORE_CLK, .NRST, .CLK_EN, .INSTR_VALID, .INSTR,
	.MEM_RDATA, .MEM, .ACC, .FLAGS, .PC_LOW_WE, .TARGET_OUT, .ADDR_FAULT);

// *** tb_top.sv ***
// Self-checking testbench for the logical datapath core
`timescale 1ns/10ps
module tb_top;
	import oalu_pkg::*;
	logic                clk;
	logic                nrst;
	logic                clk_en;
	logic                valid;
	oalu_instr_t         instr;
	logic [7:0]          rdata;
	logic                lsup;
	logic                tmo;
	logic [7:0]          pc_in;
	oalu_mem_t           mem;
	logic [7:0]          acc;
	logic [7:0]          flags;
	logic                pc_we;
	logic [7:0]          pc_out;
	logic [TARGET_W-1:0] tgt;
	logic                fault;
	int                  err_count;
	int                  samples_checked;
	logic [7:0]          adr [5] = '{8'h04, 8'h05, 8'h0c, 8'h0d, 8'h07};
	logic [7:0]          val [5] = '{8'h12, 8'h34, 8'h01, 8'hf0, 8'h10};

	oalu_core oalu_core_i (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(clk_en), .INSTR_VALID(valid),
		.INSTR(instr), .MEM_RDATA(rdata), .LOW_SUPPLY_EVT(lsup), .TIMEOUT_EVT(tmo),
		.PC_LOW_IN(pc_in), .MEM(mem), .ACC(acc), .FLAGS(flags), .PC_LOW_WE(pc_we),
		.PC_LOW_OUT(pc_out), .TARGET_OUT(tgt), .ADDR_FAULT(fault));

	// ====================
	// Access tasks
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// Answer is visible one step after the taking edge
	task automatic ex(input oalu_op_t op, input oalu_mode_t md, input logic tf,
		input logic [7:0] fd, input logic [7:0] rd);
		instr = '{op, md, tf, fd, {5'h15, fd}};
		rdata = rd;
		@(posedge clk);
		#1;
	endtask
	task automatic ld(input logic [7:0] v);
		ex(OP_AND, AM_IMMEDIATE, 1'b0, 8'h00, 8'h00);
		ex(OP_OR, AM_IMMEDIATE, 1'b0, v, 8'h00);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ====================
	// Stimulus
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end
	initial
	begin
		nrst = 1'b0;
		clk_en = 1'b1;
		valid = 1'b1;
		instr = '0;
		rdata = 8'h00;
		lsup = 1'b0;
		tmo = 1'b0;
		pc_in = 8'h40;
		repeat (4) @(posedge clk);
		#1;
		nrst = 1'b1;
		foreach (adr[i])
		begin
			ld(val[i]);
			ex(OP_OR, AM_DIRECT, 1'b1, adr[i], 8'h00);
		end
		foreach (adr[i])
		begin
			ld(8'h00);
			ex(OP_XOR, AM_DIRECT, 1'b0, adr[i], 8'hee);
			chk("pointer byte", val[i], acc);
		end
		ld(8'h3c);
		ex(OP_AND, AM_INDIRECT, 1'b0, 8'h00, 8'h0f);
		chk("ind addr", 16'h1234, mem.addr);
		chk("read req", 16'h0001, {15'h0000, mem.req});
		chk("and acc", 8'h0c, acc);
		ex(OP_AND, AM_INDIRECT, 1'b1, 8'h00, 8'hf0);
		chk("file write", 16'h0100, {7'h00, mem.we, mem.wdata});
		chk("zero set", 16'h0001, {15'h0000, flags[2]});
		ex(OP_OR, AM_DP_OFFSET, 1'b0, 8'hff, 8'h41);
		chk("dp addr", 16'h02ef, mem.addr);
		chk("or acc", 8'h4d, acc);
		ex(OP_XOR, AM_SP_OFFSET, 1'b0, 8'h10, 8'h4d);
		chk("sp addr", 16'h0020, mem.addr);
		chk("xor acc", 16'h0000, {fault, acc});
		ex(OP_OR, AM_SP_OFFSET, 1'b0, 8'h0f, 8'hff);
		chk("low offset", 16'h0100, {fault, acc});
		ex(OP_OR, AM_DIRECT, 1'b1, 8'h00, 8'hff);
		chk("direct zero", 16'h0002, {fault, mem.we});
		ex(OP_NOT, AM_DIRECT, 1'b0, 8'h20, 8'h5a);
		chk("not acc", 8'ha5, acc);
		ex(OP_NOT, AM_DIRECT, 1'b1, 8'hff, 8'h00);
		chk("not addr", 16'h00ff, mem.addr);
		chk("not data", 8'hff, mem.wdata);
		chk("target", {5'h15, 8'hff}, tgt);
		ex(OP_OR, AM_DIRECT, 1'b1, ADR_PC_LOW, 8'h00);
		chk("pc write", 16'h01e5, {pc_we, pc_out});
		lsup = 1'b1;
		tmo = 1'b1;
		ex(OP_NONE, AM_IMMEDIATE, 1'b0, 8'h00, 8'h00);
		lsup = 1'b0;
		tmo = 1'b0;
		chk("event bits", 2'b11, flags[4:3]);
		ld(8'ha3);
		ex(OP_OR, AM_DIRECT, 1'b1, ADR_FLAGS, 8'h00);
		chk("flag byte", 8'hbb, flags);
		ld(8'h00);
		ex(OP_XOR, AM_DIRECT, 1'b0, ADR_FLAGS, 8'h00);
		chk("flag read", 8'hbf, acc);
		chk("carry kept", 2'b11, flags[1:0]);
		clk_en = 1'b0;
		ex(OP_OR, AM_IMMEDIATE, 1'b0, 8'hff, 8'h00);
		chk("frozen acc", 8'hbf, acc);
		clk_en = 1'b1;
		ex(OP_AND, AM_IMMEDIATE, 1'b0, 8'h0f, 8'h00);
		chk("literal and", 8'h0f, acc);
		ex(OP_XOR, AM_IMMEDIATE, 1'b0, 8'hf0, 8'h00);
		chk("literal xor", 8'hff, acc);
		nrst = 1'b0;
		@(posedge clk);
		#1;
		nrst = 1'b1;
		chk("reset state", 16'h0000, {flags, acc});
		print_verdict();
	end
endmodule
